// ### hdl/tsm_pkg.sv
// Shared constants and types of the touch sensor status map
`default_nettype none

package tsm_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_PRODUCT_ID  = 8'h00;
  localparam logic [7:0] ADDR_FIRMWARE    = 8'h01;
  localparam logic [7:0] ADDR_SYS_FLAGS   = 8'h10;
  localparam logic [7:0] ADDR_PROXIMITY   = 8'h31;
  localparam logic [7:0] ADDR_TOUCH       = 8'h35;
  localparam logic [7:0] ADDR_TOUCH_MODE  = 8'h36;
  localparam logic [7:0] ADDR_CAL_OUTPUT  = 8'h37;
  localparam logic [7:0] ADDR_PROX_SET2   = 8'hc6;
  localparam logic [7:0] ADDR_RSVD_LO     = 8'hfe;
  localparam logic [7:0] ADDR_RSVD_HI     = 8'hff;

  // System flag field positions
  localparam int SYS_SHOW_RESET = 5;
  localparam int SYS_TECH       = 4;
  localparam int SYS_REDUCED    = 3;
  localparam int SYS_TUNING     = 2;
  localparam int SYS_NOISE      = 1;
  localparam int SYS_FAST       = 0;

  // Other field positions
  localparam int TOUCH_BOOL_BIT = 7;
  localparam int ACK_RESET_BIT  = 7;
  localparam int NUM_CHANNELS   = 3;

  // Fixed and reset values
  localparam logic [7:0] FIRMWARE_VERSION = 8'h00;
  localparam logic [7:0] PRODUCT_ID_DEF   = 8'h5a;  // Arbitrary value
  localparam logic [7:0] UNMAPPED_VALUE   = 8'h00;
  localparam logic [6:0] BUS_ADDR_DEF     = 7'h44;
  localparam logic       SHOW_RESET_INIT  = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_PTR,
    ST_ACK_PTR,
    ST_WDATA,
    ST_ACK_WDATA,
    ST_RDATA,
    ST_RACK
  } tsm_bus_state_t;

endpackage

`default_nettype wire

// ### hdl/tsm_chan_if.sv
// Per-channel signal bundle between the status map and a channel
`timescale 1ns/10ps
`default_nettype none

interface tsm_chan_if;
  logic clock;
  logic resetn;
  logic ce;
  logic conv_done;
  logic cal_mode;
  logic proximity_raw;
  logic touch_raw;
  logic over_touch;
  logic cal_out_raw;
  logic proximity;
  logic touch;
  logic touch_mode;
  logic cal_out;

  modport chan (
    input  clock, resetn, ce, conv_done, cal_mode,
    input  proximity_raw, touch_raw, over_touch, cal_out_raw,
    output proximity, touch, touch_mode, cal_out
  );

  modport top (
    output clock, resetn, ce, conv_done, cal_mode,
    output proximity_raw, touch_raw, over_touch, cal_out_raw,
    input  proximity, touch, touch_mode, cal_out
  );
endinterface

`default_nettype wire

// ### hdl/tsm_channel.sv
// One sensing channel's status bits, latched once per conversion
`timescale 1ns/10ps
`default_nettype none

module tsm_channel (
  // Channel bundle
  tsm_chan_if.chan ch
);

  logic proximity_reg;
  logic touch_reg;
  logic touch_mode_reg;
  logic touch_mode_next;
  logic cal_out_reg;

  // threshold enters hold
  // Hold ends on release or when cal_mode drops, so a dip below the touch level keeps it
  assign touch_mode_next = !ch.cal_mode      ? 1'b0 :
                           ch.over_touch     ? 1'b1 :
                           !ch.proximity_raw ? 1'b0 :
                           touch_mode_reg;

  always_ff @(posedge ch.clock) begin
    if (!ch.resetn) begin
      proximity_reg  <= 1'b0;
      touch_reg      <= 1'b0;
      touch_mode_reg <= 1'b0;
      cal_out_reg    <= 1'b0;
    end else if (ch.ce && ch.conv_done) begin
      proximity_reg  <= ch.proximity_raw;
      touch_reg      <= ch.touch_raw;
      touch_mode_reg <= touch_mode_next;
      cal_out_reg    <= ch.cal_mode & ch.cal_out_raw;
    end
  end

  assign ch.proximity  = proximity_reg;
  assign ch.touch      = touch_reg;
  // hold kept only for calibrated channels
  // Masked at the latch, so a mode change waits for the next conversion
  assign ch.touch_mode = touch_mode_reg;
  assign ch.cal_out    = cal_out_reg;

endmodule

`default_nettype wire

// ### hdl/tsm_status_map.sv
// Status register bank of a three-channel touch sensor, over I2C
`timescale 1ns/10ps
`default_nettype none

module tsm_status_map #(
  parameter logic [6:0] BUS_ADDR   = tsm_pkg::BUS_ADDR_DEF,
  parameter logic [7:0] PRODUCT_ID = tsm_pkg::PRODUCT_ID_DEF
) (
  // Clock, reset, enable
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       ce,
  // I2C pins, open drain
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Technology strap pin
  input  wire logic       tech_projected_pin,
  // Front end status, same clock
  input  wire logic       conv_done,
  input  wire logic [2:0] proximity_raw,
  input  wire logic [2:0] touch_raw,
  input  wire logic [2:0] over_touch,
  input  wire logic [2:0] cal_mode,
  input  wire logic [2:0] cal_out_raw,
  input  wire logic       low_power_en,
  input  wire logic       reduced_rate,
  input  wire logic       tuning_busy,
  input  wire logic       noise_seen,
  input  wire logic       undebounced_prox,
  // Boolean combination settings
  input  wire logic [2:0] bool_enable,
  input  wire logic [2:0] bool_invert,
  input  wire logic       bool_all,
  // Outputs to the device
  output logic            bool_out_pin,
  output logic            full_speed_charge
);

  // Pin synchronisers
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] tech_sync_reg;
  logic       scl_last_reg;
  logic       sda_last_reg;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      scl_sync_reg  <= 2'h3;
      sda_sync_reg  <= 2'h3;
      tech_sync_reg <= 2'h0;
      scl_last_reg  <= 1'b1;
      sda_last_reg  <= 1'b1;
    end else if (ce) begin
      scl_sync_reg  <= {scl_sync_reg[0], scl_in};
      sda_sync_reg  <= {sda_sync_reg[0], sda_in};
      tech_sync_reg <= {tech_sync_reg[0], tech_projected_pin};
      scl_last_reg  <= scl_sync_reg[1];
      sda_last_reg  <= sda_sync_reg[1];
    end
  end

  // Bus conditions, from the second stage only
  wire scl_s    = scl_sync_reg[1];
  wire sda_s    = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_last_reg;
  wire scl_fall = ~scl_s & scl_last_reg;
  wire start_c  = scl_s & scl_last_reg & ~sda_s & sda_last_reg;
  wire stop_c   = scl_s & scl_last_reg & sda_s & ~sda_last_reg;

  // Bus engine state
  tsm_pkg::tsm_bus_state_t state_reg;
  tsm_pkg::tsm_bus_state_t state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] bitcnt_reg;
  logic [3:0] bitcnt_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic       rnw_reg;
  logic       rnw_next;
  logic       nack_reg;
  logic       nack_next;
  logic       drive_low_reg;
  logic       drive_low_next;
  logic       wr_strobe;
  logic [7:0] rd_data;

  wire byte_done = (bitcnt_reg == tsm_pkg::BITS_PER_BYTE);
  wire addr_hit  = (shift_reg[7:1] == BUS_ADDR);

  always_comb begin
    state_next     = state_reg;
    shift_next     = shift_reg;
    bitcnt_next    = bitcnt_reg;
    ptr_next       = ptr_reg;
    tx_next        = tx_reg;
    rnw_next       = rnw_reg;
    nack_next      = nack_reg;
    drive_low_next = drive_low_reg;
    wr_strobe      = 1'b0;
    if (stop_c) begin
      state_next     = tsm_pkg::ST_IDLE;
      drive_low_next = 1'b0;
    end else if (start_c) begin
      state_next     = tsm_pkg::ST_ADDR;
      bitcnt_next    = 4'h0;
      drive_low_next = 1'b0;
    end else if (scl_rise) begin
      shift_next = {shift_reg[6:0], sda_s};
      if (state_reg == tsm_pkg::ST_RACK) begin
        nack_next = sda_s;
      end else begin
        bitcnt_next = bitcnt_reg + 4'h1;
      end
    end else if (scl_fall) begin
      unique case (state_reg)
        tsm_pkg::ST_IDLE: begin
          drive_low_next = 1'b0;
        end
        tsm_pkg::ST_ADDR: begin
          if (byte_done && addr_hit) begin
            state_next     = tsm_pkg::ST_ACK_ADDR;
            rnw_next       = shift_reg[0];
            drive_low_next = 1'b1;
          end else if (byte_done) begin
            state_next = tsm_pkg::ST_IDLE;
          end
        end
        tsm_pkg::ST_ACK_ADDR: begin
          bitcnt_next = 4'h0;
          if (rnw_reg) begin
            state_next     = tsm_pkg::ST_RDATA;
            tx_next        = rd_data;
            ptr_next       = ptr_reg + 8'h01;
            drive_low_next = ~rd_data[7];
          end else begin
            state_next     = tsm_pkg::ST_PTR;
            drive_low_next = 1'b0;
          end
        end
        tsm_pkg::ST_PTR: begin
          if (byte_done) begin
            state_next     = tsm_pkg::ST_ACK_PTR;
            ptr_next       = shift_reg;
            drive_low_next = 1'b1;
          end
        end
        tsm_pkg::ST_ACK_PTR, tsm_pkg::ST_ACK_WDATA: begin
          state_next     = tsm_pkg::ST_WDATA;
          bitcnt_next    = 4'h0;
          drive_low_next = 1'b0;
        end
        tsm_pkg::ST_WDATA: begin
          if (byte_done) begin
            state_next     = tsm_pkg::ST_ACK_WDATA;
            wr_strobe      = 1'b1;
            ptr_next       = ptr_reg + 8'h01;
            drive_low_next = 1'b1;
          end
        end
        tsm_pkg::ST_RDATA: begin
          if (byte_done) begin
            state_next     = tsm_pkg::ST_RACK;
            drive_low_next = 1'b0;
          end else begin
            tx_next        = {tx_reg[6:0], 1'b0};
            drive_low_next = ~tx_reg[6];
          end
        end
        tsm_pkg::ST_RACK: begin
          bitcnt_next = 4'h0;
          if (nack_reg) begin
            state_next = tsm_pkg::ST_IDLE;
          end else begin
            state_next     = tsm_pkg::ST_RDATA;
            tx_next        = rd_data;
            ptr_next       = ptr_reg + 8'h01;
            drive_low_next = ~rd_data[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg     <= tsm_pkg::ST_IDLE;
      shift_reg     <= 8'h00;
      bitcnt_reg    <= 4'h0;
      ptr_reg       <= 8'h00;
      tx_reg        <= 8'h00;
      rnw_reg       <= 1'b0;
      nack_reg      <= 1'b1;
      drive_low_reg <= 1'b0;
    end else if (ce) begin
      state_reg     <= state_next;
      shift_reg     <= shift_next;
      bitcnt_reg    <= bitcnt_next;
      ptr_reg       <= ptr_next;
      tx_reg        <= tx_next;
      rnw_reg       <= rnw_next;
      nack_reg      <= nack_next;
      drive_low_reg <= drive_low_next;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low_reg;

  // Channel bundles
  logic [2:0] ch_proximity;
  logic [2:0] ch_touch;
  logic [2:0] ch_touch_mode;
  logic [2:0] ch_cal_out;

  for (genvar i = 0; i < tsm_pkg::NUM_CHANNELS; i++) begin : g_ch
    tsm_chan_if ch_if ();
    assign ch_if.clock         = clock;
    assign ch_if.resetn        = resetn;
    assign ch_if.ce            = ce;
    assign ch_if.conv_done     = conv_done;
    assign ch_if.cal_mode      = cal_mode[i];
    assign ch_if.proximity_raw = proximity_raw[i];
    assign ch_if.touch_raw     = touch_raw[i];
    assign ch_if.over_touch    = over_touch[i];
    assign ch_if.cal_out_raw   = cal_out_raw[i];
    assign ch_proximity[i]     = ch_if.proximity;
    assign ch_touch[i]         = ch_if.touch;
    assign ch_touch_mode[i]    = ch_if.touch_mode;
    assign ch_cal_out[i]       = ch_if.cal_out;
    tsm_channel u_channel (
      .ch (ch_if.chan)
    );
  end

  // Boolean combination of channel touches
  wire [2:0] bool_terms = touch_raw ^ bool_invert;
  wire       bool_and   = &(bool_terms | ~bool_enable) & (|bool_enable);
  wire       bool_or    = |(bool_terms & bool_enable);
  wire       bool_value = bool_all ? bool_and : bool_or;

  // Reset acknowledge write
  wire ack_write = wr_strobe && (ptr_reg == tsm_pkg::ADDR_PROX_SET2) &&
                   shift_reg[tsm_pkg::ACK_RESET_BIT];

  // System state, refreshed per conversion except the show-reset flag
  logic show_reset_reg;
  logic tech_reg;
  logic reduced_reg;
  logic tuning_reg;
  logic noise_reg;
  logic fast_reg;
  logic bool_reg;

  // reset sets the flag
  // Reset is the only setter, and it wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      show_reset_reg <= tsm_pkg::SHOW_RESET_INIT;
    end else if (ce && ack_write) begin
      show_reset_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tech_reg    <= 1'b0;
      reduced_reg <= 1'b0;
      tuning_reg  <= 1'b0;
      noise_reg   <= 1'b0;
      fast_reg    <= 1'b0;
      bool_reg    <= 1'b0;
    end else if (ce && conv_done) begin
      tech_reg    <= tech_sync_reg[1];
      reduced_reg <= low_power_en & reduced_rate & ~undebounced_prox;
      tuning_reg  <= tuning_busy;
      noise_reg   <= noise_seen;
      fast_reg    <= undebounced_prox;
      bool_reg    <= bool_value;
    end
  end

  assign full_speed_charge = fast_reg & low_power_en;
  assign bool_out_pin = bool_reg;

  // Register images
  logic [7:0] sys_flags;
  always_comb begin
    sys_flags = 8'h00;
    sys_flags[tsm_pkg::SYS_SHOW_RESET] = show_reset_reg;
    sys_flags[tsm_pkg::SYS_TECH]    = tech_reg;
    sys_flags[tsm_pkg::SYS_REDUCED] = reduced_reg;
    sys_flags[tsm_pkg::SYS_TUNING]  = tuning_reg;
    sys_flags[tsm_pkg::SYS_NOISE]   = noise_reg;
    sys_flags[tsm_pkg::SYS_FAST]    = fast_reg;
  end

  wire [7:0] prox_byte  = {5'h00, ch_proximity};
  // touch byte, boolean in bit 7
  wire [7:0] touch_byte = {bool_reg, 4'h0, ch_touch};
  wire [7:0] mode_byte  = {5'h00, ch_touch_mode};
  wire [7:0] cal_byte   = {5'h00, ch_cal_out};

  // Read selection
  wire sel_id    = (ptr_reg == tsm_pkg::ADDR_PRODUCT_ID);
  wire sel_fw    = (ptr_reg == tsm_pkg::ADDR_FIRMWARE);
  wire sel_sys   = (ptr_reg == tsm_pkg::ADDR_SYS_FLAGS);
  wire sel_prox  = (ptr_reg == tsm_pkg::ADDR_PROXIMITY);
  wire sel_touch = (ptr_reg == tsm_pkg::ADDR_TOUCH);
  wire sel_mode  = (ptr_reg == tsm_pkg::ADDR_TOUCH_MODE);
  wire sel_cal   = (ptr_reg == tsm_pkg::ADDR_CAL_OUTPUT);

  // FE, FF and other holes read as the unmapped value
  assign rd_data = sel_id    ? PRODUCT_ID :
                   sel_fw    ? tsm_pkg::FIRMWARE_VERSION :
                   sel_sys   ? sys_flags :
                   sel_prox  ? prox_byte :
                   sel_touch ? touch_byte :
                   sel_mode  ? mode_byte :
                   sel_cal   ? cal_byte :
                   tsm_pkg::UNMAPPED_VALUE;

endmodule

`default_nettype wire

// ### testbench/tsm_host_bfm.sv
// I2C host master model for the status map bus pins
`timescale 1ns/10ps
`default_nettype none

module tsm_host_bfm #(
  parameter logic [6:0] DEV_ADDR = 7'h44
) (
  // Clock
  input  wire logic clock,
  // Bus wires, pull high means host drives SDA low
  input  wire logic sda,
  output var  logic scl,
  output var  logic pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Device only moves SDA after SCL falls, so mid-high sampling is safe
  task automatic bit_io(input logic b, output logic r);
    pull <= !b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    r = sda;
    tick(3);
    scl <= 1'b0;
    tick(3);
  endtask

  task automatic start();
    pull <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(5);
    pull <= 1'b1;
    tick(5);
    scl <= 1'b0;
    tick(3);
  endtask

  task automatic stop();
    pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(5);
    pull <= 1'b0;
    tick(5);
  endtask

  task automatic xfer(input logic [7:0] tx, input logic m_ack,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(m_ack, r);
    ack = !r;
  endtask

  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d,
                        output logic ok);
    logic [7:0] x;
    logic       a0, a1, a2;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, x, a0);
    xfer(ptr, 1'b1, x, a1);
    xfer(d, 1'b1, x, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d,
                        output logic ok);
    logic [7:0] x;
    logic       a0, a1, a2;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, x, a0);
    xfer(ptr, 1'b1, x, a1);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, x, a2);
    // Host refuses a second byte
    xfer(8'hff, 1'b1, d, x[0]);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

`default_nettype wire

// ### testbench/tsm_status_map_chk.sv
// Port assertions for the touch sensor status map
`timescale 1ns/10ps
`default_nettype none

module tsm_status_map_chk (
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       ce,
  // Bus pins
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Front end
  input wire logic       conv_done,
  input wire logic [2:0] touch_raw,
  input wire logic       low_power_en,
  input wire logic       undebounced_prox,
  input wire logic [2:0] bool_enable,
  input wire logic [2:0] bool_invert,
  input wire logic       bool_all,
  // Outputs
  input wire logic       bool_out_pin,
  input wire logic       full_speed_charge
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  wire logic       take = ce && conv_done;
  wire logic [2:0] term = touch_raw ^ bool_invert;
  wire logic       any_on = |(bool_enable & term);
  wire logic       all_on = (&(term | ~bool_enable)) && (|bool_enable);

  a_sda_drain_only: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  a_fast_normal: assert property (
    !low_power_en |-> !full_speed_charge)
    else $error("fast charge in normal power");
  a_fast_set: assert property (
    take && undebounced_prox ##1 low_power_en |-> full_speed_charge)
    else $error("fast charge missing");
  a_fast_clear: assert property (
    take && !undebounced_prox |=> !full_speed_charge)
    else $error("fast charge stuck");
  a_bool_or_term: assert property (
    take && !bool_all |=> bool_out_pin == $past(any_on))
    else $error("boolean or wrong");
  a_bool_and_term: assert property (
    take && bool_all |=> bool_out_pin == $past(all_on))
    else $error("boolean and wrong");
  a_bool_hold: assert property (!take |=> $stable(bool_out_pin))
    else $error("boolean moved between conversions");
  a_reset_quiet: assert property (
    $rose(resetn) && $past(ce) |-> !sda_oe && !bool_out_pin)
    else $error("outputs busy after reset");
  a_ack_scl_low: assert property (
    $rose(sda_oe) |-> !$past(scl_in, 2))
    else $error("SDA pulled while SCL high");

  c_bool_and: cover property (take && bool_all && all_on);
  c_ack: cover property ($rose(sda_oe));
  c_fast: cover property (full_speed_charge);
endmodule

bind tsm_status_map tsm_status_map_chk u_chk (
  .clock, .resetn, .ce, .scl_in, .sda_out, .sda_oe, .conv_done,
  .touch_raw, .low_power_en, .undebounced_prox, .bool_enable,
  .bool_invert, .bool_all, .bool_out_pin, .full_speed_charge
);

`default_nettype wire

// ### testbench/tb_touch_sensor_status_map.sv
// Self-checking bench for the touch sensor status map
`timescale 1ns/10ps
`default_nettype none

module tb_touch_sensor_status_map;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic        conv_done = 1'b0;
  logic [31:0] stim = 32'h00000000;
  logic [31:0] seed = 32'h0000b967;
  logic [31:0] lat;
  logic [2:0]  tm;
  logic        show;
  int          error_cnt = 0;
  int          n_checks = 0;
  wire logic   scl, pull, sda_out, sda_oe, bool_out_pin, full_speed_charge;
  // Open drain line with pull-up
  wire logic   sda = !(pull | sda_oe);
  logic [7:0]  regs [10] = '{8'h00, 8'h01, 8'h10, 8'h31, 8'h35, 8'h36,
                             8'h37, 8'h20, 8'hfe, 8'hff};

  always #5 clock = ~clock;

  tsm_status_map uut (
    .clock, .resetn, .ce, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .tech_projected_pin(stim[27]), .conv_done,
    .proximity_raw(stim[2:0]), .touch_raw(stim[5:3]),
    .over_touch(stim[8:6] & stim[2:0]), .cal_mode(stim[11:9]),
    .cal_out_raw(stim[14:12]), .low_power_en(stim[15]),
    .reduced_rate(stim[16]), .tuning_busy(stim[17]), .noise_seen(stim[18]),
    .undebounced_prox(stim[19]), .bool_enable(stim[22:20]),
    .bool_invert(stim[25:23]), .bool_all(stim[26]), .bool_out_pin,
    .full_speed_charge
  );

  tsm_host_bfm host (.clock, .sda, .scl, .pull);

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] expect_byte(input logic [7:0] a);
    logic [2:0] v, e;
    logic       b;
    v = lat[5:3] ^ lat[25:23];
    e = lat[22:20];
    b = lat[26] ? ((&(v | ~e)) && (|e)) : (|(v & e));
    case (a)
      tsm_pkg::ADDR_PRODUCT_ID: return tsm_pkg::PRODUCT_ID_DEF;
      tsm_pkg::ADDR_SYS_FLAGS:  return {2'b00, show, lat[27],
        lat[15] & lat[16] & !lat[19], lat[17], lat[18], lat[19]};
      tsm_pkg::ADDR_PROXIMITY:  return {5'h00, lat[2:0]};
      tsm_pkg::ADDR_TOUCH:      return {b, 4'h0, lat[5:3]};
      tsm_pkg::ADDR_TOUCH_MODE: return {5'h00, tm};
      tsm_pkg::ADDR_CAL_OUTPUT: return {5'h00, lat[11:9] & lat[14:12]};
      default:                  return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      tsm_pkg::ADDR_SYS_FLAGS:  return 8'h3f;
      tsm_pkg::ADDR_PROXIMITY:  return {5'h00, ~lat[11:9]};
      tsm_pkg::ADDR_TOUCH:      return {5'h1f, ~lat[11:9]};
      tsm_pkg::ADDR_TOUCH_MODE: return 8'h07;
      tsm_pkg::ADDR_CAL_OUTPUT: return 8'h07;
      default:                  return 8'hff;
    endcase
  endfunction

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", what, e, g);
      error_cnt++;
    end
  endtask

  task automatic chk_reg(input logic [7:0] a);
    logic [7:0] got, m, e;
    logic       ok;
    string      nm;
    host.rd_reg(a, got, ok);
    m = mask(a);
    e = expect_byte(a) & m;
    nm = $sformatf("reg %h", a);
    chk("read ack", 8'h01, {7'h00, ok});
    chk(nm, e, got & m);
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    tick(10);
    resetn <= 1'b1;
    lat = '0;
    tm = '0;
    show = 1'b1;
    tick(4);
  endtask

  task automatic convert();
    conv_done <= 1'b1;
    tick(1);
    conv_done <= 1'b0;
    lat = stim;
    tm = (tm | (lat[11:9] & lat[8:6] & lat[2:0])) & lat[11:9] & lat[2:0];
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    tick(80000);
    error_cnt++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    logic [7:0]  b;
    logic        ok;
    do_reset();
    foreach (regs[k]) chk_reg(regs[k]);
    r = rnd();
    host.wr_reg(tsm_pkg::ADDR_PRODUCT_ID, r[7:0], ok);
    host.wr_reg(tsm_pkg::ADDR_SYS_FLAGS, 8'h00, ok);
    host.wr_reg(tsm_pkg::ADDR_PROX_SET2, 8'h7f, ok);
    chk("write ack", 8'h01, {7'h00, ok});
    chk_reg(tsm_pkg::ADDR_PRODUCT_ID);
    chk_reg(tsm_pkg::ADDR_SYS_FLAGS);
    host.wr_reg(tsm_pkg::ADDR_PROX_SET2, 8'h80, ok);
    chk("ack write ack", 8'h01, {7'h00, ok});
    show = 1'b0;
    chk_reg(tsm_pkg::ADDR_SYS_FLAGS);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      r[27:26] = i[1:0];
      stim <= r;
      tick(4);
      if (i == 1) begin
        // A frozen clock enable must swallow the conversion
        ce <= 1'b0;
        conv_done <= 1'b1;
        tick(1);
        ce <= 1'b1;
        conv_done <= 1'b0;
        tick(1);
        chk_reg(tsm_pkg::ADDR_PROXIMITY);
      end
      convert();
      stim <= rnd();
      tick(2);
      b = expect_byte(tsm_pkg::ADDR_TOUCH);
      chk("bool pin", {7'h00, b[7]}, {7'h00, bool_out_pin});
      b = {7'h00, lat[19] & stim[15]};
      chk("fast", b, {7'h00, full_speed_charge});
      foreach (regs[k]) chk_reg(regs[k]);
    end
    do_reset();
    chk_reg(tsm_pkg::ADDR_SYS_FLAGS);
    conclude();
  end
endmodule

`default_nettype wire
